/* include/xbpa_pkg.sv */
// How it works
// RULE1: Only pins P0.0 to P2.6 with a clear bypass bit are candidates.
// RULE2: Selected first UART takes P0.4 transmit and P0.5 receive, top priority.
// RULE3: Selected second SPI takes P1.0 to P1.2, second priority.
// RULE4: Second SPI also takes P1.3 for slave select in four-wire mode.
// RULE5: Other functions in priority order take lowest free candidate pins.
// RULE6: Assigned or bypassed pins are skipped during allocation.
// RULE7: Software enables the crossbar before using pins as digital outputs.
// RULE8: All pin drivers stay off while the global enable is clear.
// RULE9: SMBus data and clock pins are forced open-drain when selected.
// RULE10: First SPI slave select gets a pin only in four-wire mode.
// RULE11: First SPI wire mode shifts pins of all lower priority functions.
// RULE12: Software clears bypass bits of the fixed UART and second SPI pins.
// RULE13: Software bypasses pins used for analog, GPIO or dedicated functions.
// RULE14: Bypass bit n maps to pin n; 0x0c skips P0.2 and P0.3.
// RULE15: Flexible order: first SPI, SDA, SCL, comparators, clock, captures, timers.
// RULE16: Pin P2.7 is never a candidate, whatever its bypass bit.
// RULE17: First select bits 0..7: UART, SPI, SMBus, clock, cmp0, cmp0 async, cmp1, cmp1 async.
// RULE18: Second select: bit6 second SPI, bit5 timer1, bit4 timer0, bit3 counter.
package xbpa_pkg;

  localparam int NUM_PINS  = 24;
  localparam int NUM_FUNCS = 26;
  localparam int NUM_CEX   = 6;

  typedef logic [4:0] xbpa_func_t;

  // Function slots in priority order
  localparam xbpa_func_t F_TX        = 5'h00;
  localparam xbpa_func_t F_RX        = 5'h01;
  localparam xbpa_func_t F_SPIB_SCK  = 5'h02;
  localparam xbpa_func_t F_SPIB_MISO = 5'h03;
  localparam xbpa_func_t F_SPIB_MOSI = 5'h04;
  localparam xbpa_func_t F_SPIB_NSS  = 5'h05;
  localparam xbpa_func_t F_SPIA_SCK  = 5'h06;
  localparam xbpa_func_t F_SPIA_MISO = 5'h07;
  localparam xbpa_func_t F_SPIA_MOSI = 5'h08;
  localparam xbpa_func_t F_SPIA_NSS  = 5'h09;
  localparam xbpa_func_t F_SDA       = 5'h0a;
  localparam xbpa_func_t F_SCL       = 5'h0b;
  localparam xbpa_func_t F_CMP0      = 5'h0c;
  localparam xbpa_func_t F_CMP0_ASY  = 5'h0d;
  localparam xbpa_func_t F_CMP1      = 5'h0e;
  localparam xbpa_func_t F_CMP1_ASY  = 5'h0f;
  localparam xbpa_func_t F_CLK_OUT   = 5'h10;
  localparam xbpa_func_t F_CAP_FIRST = 5'h11;
  localparam xbpa_func_t F_CNT_IN    = 5'h17;
  localparam xbpa_func_t F_TMR0_IN   = 5'h18;
  localparam xbpa_func_t F_TMR1_IN   = 5'h19;

  // Fixed pin numbers, pin index = port * 8 + bit
  localparam int PIN_TX        = 4;
  localparam int PIN_RX        = 5;
  localparam int PIN_SPIB_SCK  = 8;
  localparam int PIN_SPIB_MISO = 9;
  localparam int PIN_SPIB_MOSI = 10;
  localparam int PIN_SPIB_NSS  = 11;

  // P2.7 left out of the candidate set
  localparam logic [23:0] CAND_MASK = 24'h7fffff;

  // First select bit positions
  localparam int SEL1_UART = 0;
  localparam int SEL1_SPIA = 1;
  localparam int SEL1_SMB  = 2;
  localparam int SEL1_SYSC = 3;
  localparam int SEL1_CMP0  = 4;
  localparam int SEL1_CMP0A = 5;
  localparam int SEL1_CMP1  = 6;
  localparam int SEL1_CMP1A = 7;
  // Second select bit positions
  localparam int SEL2_SPIB = 6;
  localparam int SEL2_TMR1 = 5;
  localparam int SEL2_TMR0 = 4;
  localparam int SEL2_CNT  = 3;
  localparam int SEL2_CEX_HI = 2;

  localparam logic [7:0] BYPASS_NONE = 8'h00;
  localparam logic [7:0] BYPASS_OSC  = 8'h0c;
  localparam logic       FUNC_IN_IDLE = 1'b1;

  typedef struct packed {
    logic [7:0]  crossbar_select_first;
    logic [7:0]  crossbar_select_second;
    logic        crossbar_global_enable;
    logic [7:0]  port_two_bypass_mask;
    logic [7:0]  port_one_bypass_mask;
    logic [7:0]  port_zero_bypass_mask;
    logic [23:0] port_output_mode_select;
    logic        slave_select_mode_high;
    logic        slave_select_mode_low;
    logic        second_spi_four_wire;
  } xbpa_cfg_s;

  typedef struct packed {
    logic       valid;
    xbpa_func_t func;
  } xbpa_slot_s;

endpackage

/* design/xbpa_top.sv */
`timescale 1ns/1ps
`default_nettype none
module xbpa_top
(
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire xbpa_pkg::xbpa_cfg_s               cfg,
  input  wire logic [xbpa_pkg::NUM_FUNCS-1:0]    func_out,
  input  wire logic [xbpa_pkg::NUM_FUNCS-1:0]    func_oe,
  input  wire logic [xbpa_pkg::NUM_PINS-1:0]     gpio_out,
  input  wire logic [xbpa_pkg::NUM_PINS-1:0]     pin_in,
  output logic      [xbpa_pkg::NUM_PINS-1:0]     pin_out,
  output logic      [xbpa_pkg::NUM_PINS-1:0]     pin_oe,
  output logic      [xbpa_pkg::NUM_FUNCS-1:0]    func_in,
  output xbpa_pkg::xbpa_slot_s [xbpa_pkg::NUM_PINS-1:0] pin_map
);
  import xbpa_pkg::*;

  logic [NUM_FUNCS-1:0]      want;
  logic [NUM_PINS-1:0]       cand;
  logic [NUM_PINS-1:0]       taken;
  logic [NUM_PINS-1:0]       fixed_mask;
  xbpa_slot_s [NUM_PINS-1:0] map_nxt;
  xbpa_slot_s [NUM_PINS-1:0] map_r;
  logic [NUM_PINS-1:0]       pin_out_nxt;
  logic [NUM_PINS-1:0]       pin_oe_nxt;
  logic [NUM_PINS-1:0]       pin_out_r;
  logic [NUM_PINS-1:0]       pin_oe_r;
  logic [NUM_PINS-1:0]       sync1_r;
  logic [NUM_PINS-1:0]       sync2_r;
  logic [NUM_FUNCS-1:0]      func_in_nxt;
  logic [NUM_FUNCS-1:0]      func_in_r;
  logic                      four_wire0;
  logic                      uart_en;
  logic                      spib_en;
  logic [2:0]                cex_cnt;
  xbpa_cfg_s                 cfg_q_r;
  logic [NUM_PINS-1:0]       byp_q;
  logic [NUM_PINS-1:0]       map_valid;
  logic [NUM_PINS-1:0]       smb_bad;
  logic [NUM_PINS-1:0]       nss0_hit;

  // Decode the select bits into wanted function slots
  assign uart_en    = cfg.crossbar_select_first[SEL1_UART];  // [RULE17]
  assign spib_en    = cfg.crossbar_select_second[SEL2_SPIB]; // [RULE18]
  assign four_wire0 = cfg.slave_select_mode_high
                    | cfg.slave_select_mode_low;              // [RULE10]
  assign cex_cnt    = cfg.crossbar_select_second[SEL2_CEX_HI:0];

  // Flexible functions only; bit 7 of the second select is never read
  always_comb
  begin
    want              = '0;
    want[F_SPIA_SCK]  = cfg.crossbar_select_first[SEL1_SPIA]; // [RULE17]
    want[F_SPIA_MISO] = cfg.crossbar_select_first[SEL1_SPIA];
    want[F_SPIA_MOSI] = cfg.crossbar_select_first[SEL1_SPIA];
    want[F_SPIA_NSS]  = cfg.crossbar_select_first[SEL1_SPIA]
                      & four_wire0;                            // [RULE10]
    want[F_SDA]       = cfg.crossbar_select_first[SEL1_SMB];
    want[F_SCL]       = cfg.crossbar_select_first[SEL1_SMB];
    want[F_CMP0]      = cfg.crossbar_select_first[SEL1_CMP0];
    want[F_CMP0_ASY]  = cfg.crossbar_select_first[SEL1_CMP0A];
    want[F_CMP1]      = cfg.crossbar_select_first[SEL1_CMP1];
    want[F_CMP1_ASY]  = cfg.crossbar_select_first[SEL1_CMP1A];
    want[F_CLK_OUT]   = cfg.crossbar_select_first[SEL1_SYSC];
    for (int k = 0; k < NUM_CEX; k++)
    begin
      want[int'(F_CAP_FIRST) + k] = (int'(cex_cnt) > k);
    end
    want[F_CNT_IN]    = cfg.crossbar_select_second[SEL2_CNT]; // [RULE18]
    want[F_TMR0_IN]   = cfg.crossbar_select_second[SEL2_TMR0];
    want[F_TMR1_IN]   = cfg.crossbar_select_second[SEL2_TMR1];
  end

  // Candidate pins: bit n of each mask is pin n of that port
  // Invert first, then mask, so a clear P2.7 bypass bit never makes a candidate
  assign cand = ~{cfg.port_two_bypass_mask, cfg.port_one_bypass_mask,
                  cfg.port_zero_bypass_mask}
                & CAND_MASK; // [RULE1] [RULE14] [RULE16]

  // Priority allocation: fixed pins first, then lowest free candidate
  always_comb
  begin
    logic found;
    found   = 1'b0;
    taken   = '0;
    map_nxt = '0;
    if (uart_en)
    begin
      map_nxt[PIN_TX] = '{valid: 1'b1, func: F_TX};          // [RULE2]
      map_nxt[PIN_RX] = '{valid: 1'b1, func: F_RX};
      taken[PIN_TX]   = 1'b1;
      taken[PIN_RX]   = 1'b1;
    end
    if (spib_en)
    begin
      map_nxt[PIN_SPIB_SCK]  = '{valid: 1'b1, func: F_SPIB_SCK};  // [RULE3]
      map_nxt[PIN_SPIB_MISO] = '{valid: 1'b1, func: F_SPIB_MISO};
      map_nxt[PIN_SPIB_MOSI] = '{valid: 1'b1, func: F_SPIB_MOSI};
      taken[PIN_SPIB_SCK]    = 1'b1;
      taken[PIN_SPIB_MISO]   = 1'b1;
      taken[PIN_SPIB_MOSI]   = 1'b1;
      if (cfg.second_spi_four_wire)
      begin
        map_nxt[PIN_SPIB_NSS] = '{valid: 1'b1, func: F_SPIB_NSS}; // [RULE4]
        taken[PIN_SPIB_NSS]   = 1'b1;
      end
    end
    // Slot index order is the priority order [RULE15]
    for (int s = int'(F_SPIA_SCK); s < NUM_FUNCS; s++)
    begin
      found = 1'b0;
      if (want[s])
      begin
        for (int p = 0; p < NUM_PINS; p++)
        begin
          if (!found && cand[p] && !taken[p])  // [RULE5] [RULE6] [RULE11]
          begin
            map_nxt[p] = '{valid: 1'b1, func: 5'(s)};
            taken[p]   = 1'b1;
            found      = 1'b1;
          end
        end
      end
    end
  end

  // Per-pin driver: assigned function or GPIO latch, push-pull or open-drain
  generate
    for (genvar p = 0; p < NUM_PINS; p++)
    begin : g_drv
      logic val;
      logic drv;
      logic od;
      always_comb
      begin
        val = gpio_out[p];
        drv = 1'b1;
        od  = ~cfg.port_output_mode_select[p];
        if (map_nxt[p].valid)
        begin
          val = func_out[map_nxt[p].func];
          drv = func_oe[map_nxt[p].func];
          if (map_nxt[p].func == F_SDA || map_nxt[p].func == F_SCL)
          begin
            od = 1'b1;                                       // [RULE9]
          end
        end
        pin_out_nxt[p] = val;
        pin_oe_nxt[p]  = cfg.crossbar_global_enable & drv
                       & (~od | ~val);                       // [RULE8]
      end
    end
  endgenerate

  // Registered pin map and pin drive
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      map_r     <= '0;
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end
    else
    begin
      map_r     <= map_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  // Two-stage synchroniser on pin inputs
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Route pin levels back to the peripherals; unrouted inputs idle high
  always_comb
  begin
    func_in_nxt = {NUM_FUNCS{FUNC_IN_IDLE}};
    for (int p = 0; p < NUM_PINS; p++)
    begin
      if (map_r[p].valid)
      begin
        func_in_nxt[map_r[p].func] = sync2_r[p];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      func_in_r <= {NUM_FUNCS{FUNC_IN_IDLE}};
    end
    else
    begin
      func_in_r <= func_in_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;
  assign func_in = func_in_r;
  assign pin_map = map_r;

  // Checking helpers: the config that produced map_r
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cfg_q_r <= '0;
    end
    else
    begin
      cfg_q_r <= cfg;
    end
  end

  assign byp_q = {cfg_q_r.port_two_bypass_mask,
                  cfg_q_r.port_one_bypass_mask,
                  cfg_q_r.port_zero_bypass_mask};
  assign fixed_mask = 24'h000f30;
  generate
    for (genvar p = 0; p < NUM_PINS; p++)
    begin : g_chk
      assign map_valid[p] = map_r[p].valid;
      assign nss0_hit[p]  = map_r[p].valid && map_r[p].func == F_SPIA_NSS;
      assign smb_bad[p]   = map_r[p].valid && pin_oe_r[p] && pin_out_r[p]
                          && (map_r[p].func == F_SDA
                          ||  map_r[p].func == F_SCL);
    end
  endgenerate

  // All checks run on the core clock and sleep through reset
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_DRV_OFF: assert property ( // [RULE8]
    !cfg_q_r.crossbar_global_enable |-> pin_oe_r == '0)
    else $error("pin driven while crossbar disabled");

  AST_UART_FIXED: assert property ( // [RULE2]
    cfg_q_r.crossbar_select_first[SEL1_UART] |->
      map_r[PIN_TX] == {1'b1, F_TX} && map_r[PIN_RX] == {1'b1, F_RX})
    else $error("uart not on fixed pins");

  AST_SPIB_FIXED: assert property ( // [RULE3]
    cfg_q_r.crossbar_select_second[SEL2_SPIB] |->
      map_r[PIN_SPIB_SCK] == {1'b1, F_SPIB_SCK}
      && map_r[PIN_SPIB_MISO] == {1'b1, F_SPIB_MISO}
      && map_r[PIN_SPIB_MOSI] == {1'b1, F_SPIB_MOSI})
    else $error("second spi not on fixed pins");

  AST_SPIB_NSS: assert property ( // [RULE4]
    (map_r[PIN_SPIB_NSS] == {1'b1, F_SPIB_NSS}) ==
      (cfg_q_r.crossbar_select_second[SEL2_SPIB]
       && cfg_q_r.second_spi_four_wire))
    else $error("second spi slave select pin wrong");

  AST_NO_P27: assert property ( // [RULE16]
    !map_r[NUM_PINS-1].valid)
    else $error("pin P2.7 assigned");

  AST_BYPASS: assert property ( // [RULE1] [RULE6]
    (map_valid & byp_q & ~fixed_mask) == '0)
    else $error("bypassed pin assigned");

  AST_SMB_OD: assert property ( // [RULE9]
    smb_bad == '0)
    else $error("smbus pin driven high");

  AST_NSS0_3W: assert property ( // [RULE10]
    !(cfg_q_r.slave_select_mode_high || cfg_q_r.slave_select_mode_low) |->
      nss0_hit == '0)
    else $error("slave select routed in three-wire mode");

  AST_LOWEST: assert property ( // [RULE5]
    cfg_q_r.crossbar_select_first == 8'h02
    && cfg_q_r.crossbar_select_second == 8'h00 && byp_q == '0 |->
      map_r[0] == {1'b1, F_SPIA_SCK} && map_r[2] == {1'b1, F_SPIA_MOSI})
    else $error("first spi not on lowest pins");

  AST_SHIFT: assert property ( // [RULE11]
    cfg_q_r.crossbar_select_first == 8'h06
    && cfg_q_r.crossbar_select_second == 8'h00 && byp_q == '0 |->
      map_r[cfg_q_r.slave_select_mode_high
            || cfg_q_r.slave_select_mode_low ? 4 : 3] == {1'b1, F_SDA})
    else $error("wire mode did not shift data pin");

  AST_OSC_SKIP: assert property ( // [RULE14]
    cfg_q_r.crossbar_select_first == 8'h02
    && cfg_q_r.crossbar_select_second == 8'h00
    && byp_q == {BYPASS_NONE, BYPASS_NONE, BYPASS_OSC} |->
      map_r[4] == {1'b1, F_SPIA_MOSI})
    else $error("oscillator pins not skipped");

  AST_ORDER: assert property ( // [RULE15]
    cfg_q_r.crossbar_select_first == 8'h18
    && cfg_q_r.crossbar_select_second == 8'h00 && byp_q == '0 |->
      map_r[0] == {1'b1, F_CMP0} && map_r[1] == {1'b1, F_CLK_OUT})
    else $error("comparator not ahead of clock output");

  COV_UART: cover property (@(posedge core_clk) disable iff (sys_rst)
    map_r[PIN_TX].valid && cfg_q_r.crossbar_global_enable);
  COV_SPIA_4W: cover property (@(posedge core_clk) disable iff (sys_rst)
    map_r[3] == {1'b1, F_SPIA_NSS});
  COV_SMB: cover property (@(posedge core_clk) disable iff (sys_rst)
    map_r[4] == {1'b1, F_SDA} && pin_oe_r[4]);
  COV_OSC: cover property (@(posedge core_clk) disable iff (sys_rst)
    byp_q[7:0] == BYPASS_OSC && map_valid != '0);

endmodule
`default_nettype wire

/* tb/xbpa_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module xbpa_pad_model
(
  input  wire logic [xbpa_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [xbpa_pkg::NUM_PINS-1:0] pin_oe,
  input  wire logic [xbpa_pkg::NUM_PINS-1:0] ext_level,
  output logic      [xbpa_pkg::NUM_PINS-1:0] pin_in
);
  import xbpa_pkg::*;
  // Driven pads follow the block, released pads follow the outside world
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

/* tb/xbpa_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module xbpa_tb_top;
  import xbpa_pkg::*;
  logic                      core_clk;
  logic                      sys_rst;
  xbpa_cfg_s                 cfg;
  logic [NUM_FUNCS-1:0]      func_out;
  logic [NUM_FUNCS-1:0]      func_oe;
  logic [NUM_FUNCS-1:0]      func_in;
  logic [NUM_PINS-1:0]       gpio_out;
  logic [NUM_PINS-1:0]       ext_level;
  logic [NUM_PINS-1:0]       pin_in;
  logic [NUM_PINS-1:0]       pin_out;
  logic [NUM_PINS-1:0]       pin_oe;
  xbpa_slot_s [NUM_PINS-1:0] pin_map;
  logic [95:0]               rnd;
  xbpa_cfg_s                 rc;
  int                        num_errors;
  int                        compares;
  int                        cycles;

  xbpa_top xbpa_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg),
    .func_out(func_out), .func_oe(func_oe), .gpio_out(gpio_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .func_in(func_in), .pin_map(pin_map));
  xbpa_pad_model xbpa_pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));

  // Clock and hang guard
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input bit ok, input string msg);
    compares++;
    if (!ok)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Reference allocation: fixed pins first, then lowest free candidate
  function automatic xbpa_slot_s [NUM_PINS-1:0] ref_map(input xbpa_cfg_s c);
    xbpa_slot_s [NUM_PINS-1:0] m;
    logic [NUM_FUNCS-1:0]      req;
    logic [NUM_PINS-1:0]       free;
    int                        ncap;
    bit                        found;
    m = '0;
    ncap = c.crossbar_select_second[2:0];
    if (ncap > 6)
      ncap = 6;
    if (c.crossbar_select_first[0])
      m[5:4] = {6'h21, 6'h20};
    if (c.crossbar_select_second[6])
      m[10:8] = {6'h24, 6'h23, 6'h22};
    if (c.crossbar_select_second[6] && c.second_spi_four_wire)
      m[11] = 6'h25;
    free = ~{c.port_two_bypass_mask, c.port_one_bypass_mask,
             c.port_zero_bypass_mask} & CAND_MASK;
    for (int p = 0; p < NUM_PINS; p++)
      if (m[p].valid)
        free[p] = 1'b0;
    req = '0;
    req[8:6] = {3{c.crossbar_select_first[1]}};
    req[9] = c.crossbar_select_first[1] &
             (c.slave_select_mode_high | c.slave_select_mode_low);
    req[11:10] = {2{c.crossbar_select_first[2]}};
    req[15:12] = c.crossbar_select_first[7:4];
    req[16] = c.crossbar_select_first[3];
    for (int k = 0; k < 6; k++)
      req[17+k] = (k < ncap);
    req[25:23] = c.crossbar_select_second[5:3];
    for (int s = 6; s < NUM_FUNCS; s++)
    begin
      found = 1'b0;
      for (int p = 0; p < NUM_PINS; p++)
        if (req[s] && !found && free[p])
        begin
          m[p] = {1'b1, 5'(s)};
          free[p] = 1'b0;
          found = 1'b1;
        end
    end
    return m;
  endfunction

  task automatic check_pins(input bit with_in);
    xbpa_slot_s [NUM_PINS-1:0] em;
    logic [NUM_PINS-1:0]       eo;
    logic [NUM_PINS-1:0]       ee;
    logic [NUM_FUNCS-1:0]      ei;
    logic                      v;
    logic                      od;
    em = ref_map(cfg);
    ei = '1;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      v = em[p].valid ? func_out[em[p].func] : gpio_out[p];
      od = ~cfg.port_output_mode_select[p];
      if (em[p].valid)
        od = od | (em[p].func == F_SDA) | (em[p].func == F_SCL);
      eo[p] = v;
      ee[p] = cfg.crossbar_global_enable & (~od | ~v);
      if (em[p].valid)
        ee[p] = ee[p] & func_oe[em[p].func];
      if (em[p].valid)
        ei[em[p].func] = ee[p] ? eo[p] : ext_level[p];
    end
    cmp(pin_map === em, "pin map");
    cmp(pin_oe === ee, "pin output enable");
    cmp(pin_out === eo, "pin output value");
    if (with_in)
      cmp(func_in === ei, "routed input");
  endtask

  task automatic run_case(input xbpa_cfg_s c);
    @(negedge core_clk);
    cfg = c;
    func_out = NUM_FUNCS'($urandom());
    func_oe = NUM_FUNCS'($urandom());
    gpio_out = NUM_PINS'($urandom());
    ext_level = NUM_PINS'($urandom());
    @(negedge core_clk);
    check_pins(1'b0);
    repeat (5) @(negedge core_clk);
    check_pins(1'b1);
  endtask

  function automatic xbpa_cfg_s mk(input logic [7:0] s1, input logic [7:0] s2,
    input logic en, input logic [23:0] skip, input logic [2:0] wires);
    xbpa_cfg_s c;
    c = '0;
    c.crossbar_select_first = s1;
    c.crossbar_select_second = s2;
    c.crossbar_global_enable = en;
    {c.port_two_bypass_mask, c.port_one_bypass_mask,
     c.port_zero_bypass_mask} = skip;
    c.port_output_mode_select = '1;
    {c.slave_select_mode_high, c.slave_select_mode_low,
     c.second_spi_four_wire} = wires;
    return c;
  endfunction

  // Reset checks, hand corners, then random traffic
  initial
  begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    sys_rst = 1'b1;
    cfg = '0;
    func_out = '0;
    func_oe = '0;
    gpio_out = '0;
    ext_level = '0;
    void'($urandom(43681));
    repeat (5) @(negedge core_clk);
    cmp(pin_map === '0 && pin_oe === '0 && func_in === '1, "reset");
    sys_rst = 1'b0;
    run_case(mk(8'h02, 8'h00, 1'b1, 24'h000000, 3'h0));
    run_case(mk(8'h06, 8'h00, 1'b1, 24'h000000, 3'h0));
    run_case(mk(8'h06, 8'h00, 1'b1, 24'h000000, 3'h4));
    run_case(mk(8'h02, 8'h00, 1'b1, 24'h00000c, 3'h0));
    run_case(mk(8'h18, 8'h00, 1'b1, 24'h000000, 3'h0));
    run_case(mk(8'hff, 8'h7f, 1'b1, 24'h800000, 3'h7));
    for (int k = 0; k < 8; k++)
      run_case(mk(8'(1 << k), 8'h00, 1'b1, 24'h000000, 3'h0));
    for (int k = 3; k < 8; k++)
      run_case(mk(8'h00, 8'(1 << k), 1'b1, 24'h000000, 3'h1));
    for (int k = 0; k < 8; k++)
      run_case(mk(8'h00, 8'(k), 1'b1, 24'h000000, 3'h0));
    run_case(mk(8'hff, 8'h7f, 1'b1, 24'h00000c, 3'h7));
    run_case(mk(8'hff, 8'h7e, 1'b1, 24'h000000, 3'h0));
    run_case(mk(8'hff, 8'h7e, 1'b1, 24'h000000, 3'h2));
    run_case(mk(8'hff, 8'h7e, 1'b1, 24'h000000, 3'h4));
    run_case(mk(8'hff, 8'h7f, 1'b1, 24'h7fffff, 3'h7));
    run_case(mk(8'h07, 8'h40, 1'b1, 24'h000f30, 3'h1));
    run_case(mk(8'hff, 8'h7f, 1'b0, 24'h000000, 3'h7));
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    cmp(pin_map === '0 && pin_oe === '0 && pin_out === '0, "mid reset");
    sys_rst = 1'b0;
    for (int n = 0; n < 150; n++)
    begin
      rnd = {$urandom(), $urandom(), $urandom()};
      rc = rnd[67:0];
      rc.crossbar_global_enable = ($urandom_range(3) != 0);
      run_case(rc);
    end
    close_out();
  end
endmodule
`default_nettype wire
